// >>> bench/sec_master_model.sv
// ------------------------------------------------------------
// Controlling master on the serial pins
// ------------------------------------------------------------
module sec_master_model (
    // Clock and device output
    input  wire logic clk,
    input  wire logic serial_out,
    input  wire logic serial_out_oe,
    // Serial lines to the device
    output logic      sel_pin,
    output logic      sclk_pin,
    output logic      serial_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic line_q;
    // Pull-up shows a floating output as high
    assign line_q = serial_out_oe ? serial_out : 1'b1;
    // Idle lines at time zero
    initial
    begin
        sel_pin = 1'b0;
        sclk_pin = 1'b0;
        serial_in = 1'b0;
    end
    // Lines change only after a falling system clock edge
    task automatic gap(input int n);
        repeat (n) @(negedge clk);
    endtask : gap
    // Serial clock stays 5 clk high and low, above the sync minimum
    task automatic tick(input logic b);
        serial_in = b;
        gap(5);
        sclk_pin = 1'b1;
        gap(5);
        sclk_pin = 1'b0;
    endtask : tick
    task automatic shift(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            tick(v[i]);
    endtask : shift
    // Two idle zeros, then start bit, op and address in full
    task automatic start(input logic [7:0] hdr);
        sel_pin = 1'b1;
        gap(2);
        shift({5'h00, 3'h1, hdr}, 11);
    endtask : start
    // Deselect gap of 5 clk between instructions
    task automatic stop();
        sel_pin = 1'b0;
        serial_in = ~serial_in;
        gap(5);
    endtask : stop
    // Separate in and out lines, so no drive on a shared wire
    task automatic cmd(input logic [7:0] h, input logic [15:0] d,
                       input bit dat);
        start(h);
        if (dat)
            shift(d, 16);
        stop();
    endtask : cmd
    // Dummy bit, 16 data bits, then output enable after one more rise
    task automatic read_word(input logic [5:0] a, output logic [17:0] q);
        start({2'h2, a});
        q[16] = line_q;
        for (int i = 15; i >= 0; i--)
        begin
            tick(1'b0);
            q[i] = line_q;
        end
        tick(1'b1);
        q[17] = serial_out_oe;
        stop();
    endtask : read_word
    // Raise select while a cycle runs to see the status
    task automatic status(output logic b);
        sel_pin = 1'b1;
        gap(6);
        b = line_q;
    endtask : status
endmodule : sec_master_model

// >>> bench/test_serial_eeprom_command_port.sv
module test_serial_eeprom_command_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, sel_pin, sclk_pin, serial_in, serial_out;
    logic serial_out_oe, standby, prog_enabled, completion_flag;
    int failures = 0;
    int total_checks = 0;
    logic [17:0] rd;
    logic b;
    int c;
    // ------------------------------------------------------------
    // Device and master; short programming times keep runs brief
    // ------------------------------------------------------------
    sec_port #(.CYC_WRITE(50), .CYC_ERASE(30), .CYC_ALL(100)) u_dut (
        .clk(clk), .nrst(nrst), .sel_pin(sel_pin), .sclk_pin(sclk_pin),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .standby(standby),
        .prog_enabled(prog_enabled), .completion_flag(completion_flag));
    sec_master_model u_mst (
        .clk(clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .sel_pin(sel_pin), .sclk_pin(sclk_pin), .serial_in(serial_in));
    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input string nm, input logic [17:0] seen,
                         input logic [17:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // Bounded wait so a stuck busy flag cannot hang the run
    task automatic wait_done(input int lim, input string nm);
        c = 0;
        while (completion_flag !== 1'b1 && c < 500)
        begin
            @(negedge clk);
            c++;
        end
        check(nm, 18'(c > 0 && c <= lim), 18'h1);
    endtask : wait_done
    task automatic t_locked();
        u_mst.cmd({sec_pkg::OP_WRITE, 6'h05}, 16'h0000, 1'b1);
        check("locked", 18'(completion_flag), 18'h1);
    endtask : t_locked
    task automatic t_write();
        u_mst.cmd({sec_pkg::OP_EXT, sec_pkg::EXT_ENABLE, 4'h0}, 16'h0, 1'b0);
        check("enable", 18'(prog_enabled), 18'h1);
        u_mst.cmd({sec_pkg::OP_WRITE, 6'h05}, 16'ha5c3, 1'b1);
        check("busy_sb", 18'({standby, completion_flag}), 18'h0);
        u_mst.status(b);
        check("st_busy", 18'(b), 18'h0);
        wait_done(50, "wr_time");
        repeat (3) @(negedge clk);
        check("st_rdy", 18'({serial_out_oe, serial_out}), 18'h3);
        u_mst.stop();
        u_mst.read_word(6'h05, rd);
        check("rd_wr", rd, 18'h0a5c3);
    endtask : t_write
    task automatic t_erase();
        u_mst.cmd({sec_pkg::OP_ERASE, 6'h05}, 16'h0, 1'b0);
        wait_done(30, "er_time");
        u_mst.read_word(6'h05, rd);
        check("rd_er", rd, 18'h0ffff);
    endtask : t_erase
    task automatic t_all();
        u_mst.cmd({sec_pkg::OP_EXT, sec_pkg::EXT_ER_ALL, 4'h0}, 16'h0, 1'b0);
        wait_done(100, "erase_all_cmd_time");
        u_mst.cmd({sec_pkg::OP_EXT, sec_pkg::EXT_WR_ALL, 4'h0}, 16'h1234,
                  1'b1);
        wait_done(100, "write_all_cmd_time");
        u_mst.read_word(6'h3f, rd);
        check("rd_all_hi", rd, 18'h01234);
        u_mst.read_word(6'h0a, rd);
        check("rd_all_lo", rd, 18'h01234);
    endtask : t_all
    // Disable at the end of programming, then a refused erase
    task automatic t_disable();
        u_mst.cmd({sec_pkg::OP_EXT, sec_pkg::EXT_DISABLE, 4'h0}, 16'h0, 1'b0);
        check("disable", 18'(prog_enabled), 18'h0);
        u_mst.cmd({sec_pkg::OP_ERASE, 6'h00}, 16'h0, 1'b0);
        check("er_refused", 18'(completion_flag), 18'h1);
        u_mst.read_word(6'h00, rd);
        check("rd_kept", rd, 18'h01234);
    endtask : t_disable
    // Main sequence
    initial
    begin
        nrst = 1'b0;
        repeat (6) @(negedge clk);
        check("rst_sb", 18'({standby, prog_enabled}), 18'h2);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        t_locked();
        t_write();
        t_erase();
        t_all();
        t_disable();
        stop_test();
    end
    // Watchdog, far beyond the expected few thousand cycles
    initial
    begin
        repeat (40000) @(negedge clk);
        failures++;
        stop_test();
    end
endmodule : test_serial_eeprom_command_port

// >>> rtl/sec_buf2.sv
// ----------------------------------------------------------------
// Two-entry buffer between word store and output shifter
// ----------------------------------------------------------------
module sec_buf2 #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem_ff [2];
    logic             wp_ff;
    logic             rp_ff;
    logic [1:0]       cnt_ff;
    logic             push;
    logic             pop;

    // Handshakes; full and empty are honest counts
    assign in_ready  = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data  = mem_ff[rp_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (push)
            mem_ff[wp_ff] <= in_data;
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end
        else if (flush)
        begin
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end
        else
        begin
            if (push)
                wp_ff <= ~wp_ff;
            if (pop)
                rp_ff <= ~rp_ff;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : sec_buf2

// >>> rtl/sec_pkg.sv
package sec_pkg;
    // ------------------------------------------------------------
    // Instruction field layout and widths
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 6;
    localparam int          DATA_W       = 16;
    localparam logic [1:0]  OP_EXT       = 2'h0;
    localparam logic [1:0]  OP_WRITE     = 2'h1;
    localparam logic [1:0]  OP_READ      = 2'h2;
    localparam logic [1:0]  OP_ERASE     = 2'h3;
    localparam logic [1:0]  EXT_DISABLE  = 2'h0;
    localparam logic [1:0]  EXT_WR_ALL   = 2'h1;
    localparam logic [1:0]  EXT_ER_ALL   = 2'h2;
    localparam logic [1:0]  EXT_ENABLE   = 2'h3;
    // Bit counts after the start bit
    localparam logic [4:0]  CNT_HDR      = 5'h08;
    localparam logic [4:0]  CNT_LONG     = 5'h18;
    localparam logic [4:0]  CNT_RD_END   = 5'h19;
    localparam logic [15:0] ERASED_WORD  = 16'hffff;
    // ------------------------------------------------------------
    // Programming times
    // ------------------------------------------------------------
    localparam int          CLK_HZ       = 25_000_000;
    localparam int          T_WRITE_US   = 2000;
    localparam int          T_ERASE_US   = 1000;
    localparam int          T_ALL_US     = 15000;
    localparam int          CYC_WRITE    = T_WRITE_US * (CLK_HZ / 1_000_000);
    localparam int          CYC_ERASE    = T_ERASE_US * (CLK_HZ / 1_000_000);
    localparam int          CYC_ALL      = T_ALL_US * (CLK_HZ / 1_000_000);
    localparam int          CYC_CSL_NS   = 100;
    localparam int          CYC_CSL      = (CYC_CSL_NS * 25 + 999) / 1000;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEC_IDLE  = 2'b00,
        SEC_SHIFT = 2'b01,
        SEC_READ  = 2'b10,
        SEC_DONE  = 2'b11
    } sec_state_t;
endpackage : sec_pkg

// >>> rtl/sec_port.sv
// Operation
// - Started programming finishes despite deselect
// - Select low resets command logic
// - Sample input, advance output on rising edge
// - Stopped serial clock keeps sequence state
// - No start bit means no state change
// - Programming timer needs no serial clock
// - Start bit: select and input high
// - Execute only after 25 or 9 bits
// - Opcodes read, write, erase; six-bit address
// - Opcode zero: enable, disable, erase/write all
// - After last bit ignore until deselect
// - Read sends zero then sixteen bits MSB-first
// - Status shown after select rises again
// - No status if select steady; else float
// - Select high leaves standby at once
// - Programming disabled after reset until enabled
// - Write self-erases, finishes within 2 ms
// - Word erase sets ones within 1 ms
// - Erase/write all need enable, 15 ms
// - Output floats after last bit or deselect
module sec_port #(
    parameter int ADDR_W    = sec_pkg::ADDR_W,
    parameter int DATA_W    = sec_pkg::DATA_W,
    parameter int CYC_WRITE = sec_pkg::CYC_WRITE,
    parameter int CYC_ERASE = sec_pkg::CYC_ERASE,
    parameter int CYC_ALL   = sec_pkg::CYC_ALL
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Serial pins from the master
    input  wire logic sel_pin,
    input  wire logic sclk_pin,
    input  wire logic serial_in,
    // Serial output with enable
    output logic      serial_out,
    output logic      serial_out_oe,
    // Status
    output logic      standby,
    output logic      prog_enabled,
    output logic      completion_flag
);
    localparam int WORDS = 1 << ADDR_W;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] sel_sync_ff;
    logic [1:0] sclk_sync_ff;
    logic [1:0] din_sync_ff;
    logic       sclk_prev_ff;
    logic       sel_prev_ff;
    logic       sel_s;
    logic       din_s;
    logic       rise;
    logic       sel_rise;

    // Two flops per pin; only stage [1] is read by logic
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sel_sync_ff  <= 2'h0;
            sclk_sync_ff <= 2'h0;
            din_sync_ff  <= 2'h0;
            sclk_prev_ff <= 1'b0;
            sel_prev_ff  <= 1'b0;
        end
        else
        begin
            sel_sync_ff  <= {sel_sync_ff[0], sel_pin};
            sclk_sync_ff <= {sclk_sync_ff[0], sclk_pin};
            din_sync_ff  <= {din_sync_ff[0], serial_in};
            sclk_prev_ff <= sclk_sync_ff[1];
            sel_prev_ff  <= sel_sync_ff[1];
        end
    end

    assign sel_s    = sel_sync_ff[1];
    assign din_s    = din_sync_ff[1];
    // A held clock at either level yields no edge
    assign rise     = sclk_sync_ff[1] && !sclk_prev_ff && sel_s;
    assign sel_rise = sel_s && !sel_prev_ff;

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    sec_pkg::sec_state_t state_ff;
    logic [4:0]          cnt_ff;
    logic [23:0]         shift_ff;
    logic [1:0]          op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [4:0]          need;
    logic                hdr_end;
    logic                last_bit;
    logic [23:0]         nxt_shift;

    // Fields of the shifted instruction, opcode first
    assign nxt_shift = {shift_ff[22:0], din_s};
    assign op        = nxt_shift[23:22];
    assign addr      = nxt_shift[21:16];
    assign wdata     = nxt_shift[15:0];

    // Length of an instruction from its opcode and qualifier
    function automatic logic [4:0] bits_needed(input logic [1:0] o,
                                               input logic [1:0] q);
        if (o == sec_pkg::OP_WRITE)
            bits_needed = sec_pkg::CNT_LONG;
        else if (o == sec_pkg::OP_EXT && q == sec_pkg::EXT_WR_ALL)
            bits_needed = sec_pkg::CNT_LONG;
        else
            bits_needed = sec_pkg::CNT_HDR;
    endfunction : bits_needed

    // A0 arrives on this rise; the header alone sizes the instruction,
    // and only a long one can still be shifting after it
    assign hdr_end  = (cnt_ff + 5'h01 == sec_pkg::CNT_HDR);
    assign need     = hdr_end ? bits_needed(nxt_shift[7:6], nxt_shift[5:4])
                              : sec_pkg::CNT_LONG;
    assign last_bit = rise && (state_ff == sec_pkg::SEC_SHIFT)
                      && (cnt_ff + 5'h01 == need);

    logic exec;   // One-cycle pulse: whole non-read instruction received
    assign exec = last_bit && !(hdr_end
                                && nxt_shift[7:6] == sec_pkg::OP_READ);

    logic [4:0] rd_cnt_ff;
    logic       out_take;

    // Select low holds the sequencer in reset; start needs both high
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= sec_pkg::SEC_IDLE;
            cnt_ff   <= 5'h00;
            shift_ff <= 24'h000000;
        end
        else if (!sel_s)
        begin
            state_ff <= sec_pkg::SEC_IDLE;
            cnt_ff   <= 5'h00;
            shift_ff <= 24'h000000;
        end
        else if (rise)
        begin
            case (state_ff)
                sec_pkg::SEC_IDLE:
                begin
                    if (din_s)
                        state_ff <= sec_pkg::SEC_SHIFT;
                end
                sec_pkg::SEC_SHIFT:
                begin
                    shift_ff <= nxt_shift;
                    cnt_ff   <= cnt_ff + 5'h01;
                    if (last_bit && !exec)
                        state_ff <= sec_pkg::SEC_READ;
                    else if (exec)
                        state_ff <= sec_pkg::SEC_DONE;
                end
                sec_pkg::SEC_READ:
                begin
                    if (rd_cnt_ff == 5'h10)
                        state_ff <= sec_pkg::SEC_DONE;
                end
                sec_pkg::SEC_DONE:
                    state_ff <= sec_pkg::SEC_DONE;
                default:
                    state_ff <= sec_pkg::SEC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Word store, enable latch and programming timer
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_ff [WORDS];
    logic [23:0]       timer_ff;
    logic [1:0]        pend_ff;
    logic [ADDR_W-1:0] paddr_ff;
    logic [DATA_W-1:0] pdata_ff;
    logic              busy_ff;
    logic              start_prog;
    logic [1:0]        kind;
    logic [23:0]       dur;
    logic [1:0]        qual;
    logic [1:0]        eop;
    logic [ADDR_W-1:0] eaddr;

    // Decoded fields at execution, valid for both lengths
    assign eop   = hdr_end ? nxt_shift[7:6] : op;
    assign eaddr = hdr_end ? nxt_shift[5:0] : addr;
    assign qual  = eaddr[ADDR_W-1 -: 2];
    // 0 none, 1 word, 2 all-erase, 3 all-write
    always_comb
    begin
        kind = 2'h0;
        dur  = 24'h000000;
        if (eop == sec_pkg::OP_WRITE || eop == sec_pkg::OP_ERASE)
        begin
            kind = 2'h1;
            dur  = (eop == sec_pkg::OP_WRITE) ? 24'(CYC_WRITE)
                                              : 24'(CYC_ERASE);
        end
        else if (eop == sec_pkg::OP_EXT && qual == sec_pkg::EXT_ER_ALL)
        begin
            kind = 2'h2;
            dur  = 24'(CYC_ALL);
        end
        else if (eop == sec_pkg::OP_EXT && qual == sec_pkg::EXT_WR_ALL)
        begin
            kind = 2'h3;
            dur  = 24'(CYC_ALL);
        end
    end

    // Refused while disabled or while a cycle still runs
    assign start_prog = exec && kind != 2'h0 && prog_enabled && !busy_ff;

    // Enable latch: disabled from reset, changed only by commands
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prog_enabled <= 1'b0;
        else if (exec && eop == sec_pkg::OP_EXT
                 && qual == sec_pkg::EXT_ENABLE)
            prog_enabled <= 1'b1;
        else if (exec && eop == sec_pkg::OP_EXT
                 && qual == sec_pkg::EXT_DISABLE)
            prog_enabled <= 1'b0;
    end

    // Timer on clk only; select has no say once started
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_ff  <= 1'b0;
            timer_ff <= 24'h000000;
            pend_ff  <= 2'h0;
            paddr_ff <= '0;
            pdata_ff <= '0;
        end
        else if (start_prog)
        begin
            busy_ff  <= 1'b1;
            timer_ff <= dur;
            pend_ff  <= kind;
            paddr_ff <= eaddr;
            pdata_ff <= (eop == sec_pkg::OP_ERASE || kind == 2'h2)
                        ? sec_pkg::ERASED_WORD : wdata;
        end
        else if (busy_ff)
        begin
            timer_ff <= timer_ff - 24'h000001;
            if (timer_ff == 24'h000001)
                busy_ff <= 1'b0;
        end
    end

    // Array commits at end of cycle; write-all has no pre-erase,
    // so it is an AND of data into cells, as in real flash
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++)
        begin : g_word
            always_ff @(posedge clk)
            begin
                if (busy_ff && timer_ff == 24'h000001)
                begin
                    if (pend_ff == 2'h1 && paddr_ff == ADDR_W'(gi))
                        mem_ff[gi] <= pdata_ff;
                    else if (pend_ff == 2'h2)
                        mem_ff[gi] <= sec_pkg::ERASED_WORD;
                    else if (pend_ff == 2'h3)
                        mem_ff[gi] <= mem_ff[gi] & pdata_ff;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path: word buffered, then shifted out
    // ------------------------------------------------------------
    logic              bvalid;
    logic [DATA_W-1:0] bdata;
    logic              bready;
    logic [DATA_W-1:0] oshift_ff;
    logic              rd_load;

    assign rd_load  = last_bit && !exec;
    assign out_take = rise && state_ff == sec_pkg::SEC_READ
                      && rd_cnt_ff == 5'h00;
    assign bready   = out_take;

    sec_buf2 #(.WIDTH(DATA_W)) u_buf (
        .clk       (clk),
        .nrst      (nrst),
        .flush     (!sel_s),
        .in_valid  (rd_load),
        .in_ready  (),
        .in_data   (mem_ff[eaddr]),
        .out_valid (bvalid),
        .out_ready (bready),
        .out_data  (bdata)
    );

    // Dummy zero first, then D15 down to D0 on each rise
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_cnt_ff <= 5'h00;
            oshift_ff <= '0;
        end
        else if (!sel_s)
            rd_cnt_ff <= 5'h00;
        else if (rise && state_ff == sec_pkg::SEC_READ)
        begin
            rd_cnt_ff <= rd_cnt_ff + 5'h01;
            if (out_take && bvalid)
                oshift_ff <= bdata;
            else
                oshift_ff <= {oshift_ff[DATA_W-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Output pin, status and standby
    // ------------------------------------------------------------
    logic stat_ff;

    // Status armed by a rising select while a cycle runs; arming
    // beats a coincident clock rise so no request is lost
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            stat_ff <= 1'b0;
        else if (!sel_s)
            stat_ff <= 1'b0;
        else if (sel_rise && busy_ff)
            stat_ff <= 1'b1;
        else if (rise)
            stat_ff <= 1'b0;
    end

    // Registered pin drive; floats outside read data and status
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end
        else if (!sel_s)
        begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end
        else if (rd_load)
        begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b1;
        end
        else if (rise && state_ff == sec_pkg::SEC_READ)
        begin
            serial_out    <= (rd_cnt_ff == 5'h00) ? bdata[DATA_W-1]
                                                  : oshift_ff[DATA_W-2];
            serial_out_oe <= (rd_cnt_ff != 5'h10);
        end
        else if (stat_ff)
        begin
            serial_out    <= !busy_ff;
            serial_out_oe <= 1'b1;
        end
        else if (state_ff != sec_pkg::SEC_READ)
        begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end
    end

    // Standby only when deselected and idle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            standby         <= 1'b1;
            completion_flag <= 1'b1;
        end
        else
        begin
            standby         <= !sel_s && !busy_ff;
            completion_flag <= !busy_ff;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reset_sel: assert property (@(posedge clk) disable iff (!nrst)
        !sel_s |=> state_ff == sec_pkg::SEC_IDLE)
        else $error("sequencer not reset by deselect");
    a_no_clk_hold: assert property (@(posedge clk) disable iff (!nrst)
        sel_s && !rise && $past(sel_s) |=> $stable(cnt_ff))
        else $error("count moved without clock edge");
    a_enable_gate: assert property (@(posedge clk) disable iff (!nrst)
        $rose(busy_ff) |-> $past(prog_enabled))
        else $error("programming started while disabled");
    a_busy_runs: assert property (@(posedge clk) disable iff (!nrst)
        $rose(busy_ff) |-> busy_ff [*8])
        else $error("programming cycle cut short");
    a_float_desel: assert property (@(posedge clk) disable iff (!nrst)
        !sel_s |=> !serial_out_oe)
        else $error("output driven while deselected");
    a_status_val: assert property (@(posedge clk) disable iff (!nrst)
        stat_ff && serial_out_oe |-> serial_out == !$past(busy_ff))
        else $error("status level wrong");
    a_done_hold: assert property (@(posedge clk) disable iff (!nrst)
        state_ff == sec_pkg::SEC_DONE && sel_s
        |=> state_ff == sec_pkg::SEC_DONE)
        else $error("left done without deselect");
    a_standby_lvl: assert property (@(posedge clk) disable iff (!nrst)
        sel_s |=> !standby)
        else $error("standby while selected");
    c_prog: cover property (@(posedge clk) disable iff (!nrst) start_prog);
    c_read: cover property (@(posedge clk) disable iff (!nrst) rd_load);
    c_stat: cover property (@(posedge clk) disable iff (!nrst)
        stat_ff && !busy_ff);
endmodule : sec_port
